// ==== common/chip_map.vh ====
// Purpose: Register map and constants for the channelizer gain path
// Assumes: 12-bit register address, 8-bit register data
// Notes: Gain reset is unity; page reset selects every channel
// Function
// - Total interpolation equals channel times main factor
// - One channel stage, one main stage
// - Upper nibble picks main factor, no 3x
// - Lower nibble picks channel factor, no 12x
// - One channel factor shared by all channels
// - Channel factor one bypasses channels and summer
// - Gain held separately per channel
// - Six-bit page mask selects channels
// - Multi-bit mask writes all selected channels
// - Unsigned 12-bit gain, code over 2048
// - Gain registers reached through page mask
// - Three channels summed per converter
// - Gain ignored when channel factor is one
// - Channel order: gain, interpolation, oscillator
// - Active channel count set by link mode
// - Filter bandwidths 80, 54, 40, 27 percent
// - Ripple below 0.001 dB, rejection 85 dB
// - Bandwidth 80 percent, or 50 at total factor one
// - Equal peak passband gain at every rate
`ifndef CHIP_MAP_VH
`define CHIP_MAP_VH
`define CHIP_ADDR_PAGE 12'h008
`define CHIP_ADDR_INTERP 12'h111
`define CHIP_ADDR_GAIN_LO 12'h146
`define CHIP_ADDR_GAIN_HI 12'h147
`define CHIP_PAGE_RESET 8'h3F
`define CHIP_INTERP_RESET 8'h11
`define CHIP_GAIN_RESET 12'h800
`define CHIP_GAIN_SHIFT 11
`define CHIP_SAMPLE_MAX 16'h7FFF
`define CHIP_SAMPLE_MIN 16'h8000
`define CHIP_BW_INTERP_PCT 8'h50
`define CHIP_BW_BYPASS_PCT 8'h32
`define CHIP_FIFO_DEPTH 16
`endif

// ==== core/chip_gain_path.v ====
// Purpose: Channel gain, paging, interpolation select and summing node
// Assumes: One sample word carries I/Q of all six channels per cycle
// Notes: Filters and oscillators sit outside; this block sets their rates
//   Products and sums saturate, so an overdriven mix clips, never wraps
//   Paged reads show the lowest selected channel only
//   Link mode count is a pin and is synchronised before use
//   Rate outputs follow an interpolation write by one clock
`include "chip_map.vh"
`default_nettype none

// Simple synchronous FIFO with valid/ready on both sides
module chip_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  localparam [AW:0] FULL = DEPTH;
  reg [AW:0] count;
  reg ready_q;
  wire [AW:0] next_count;
  wire push;
  wire pop;
  // Ready is a flop, so the link side sees a clean level
  assign in_ready_o = ready_q;
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  // Fill level after this edge
  assign next_count = (push & ~pop) ? count + 1'b1 :
                      (pop & ~push) ? count - 1'b1 : count;
  // Storage write
  always @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  // Pointers and fill level
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      ready_q <= (next_count != FULL);
    end
  end
endmodule // chip_fifo

module chip_gain_path #(
  parameter SW = 16,
  parameter NCH = 6
) (
  input wire sys_clk_i,
  input wire reset_i,
  // Register port
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [11:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // Link samples: I then Q per channel, channel 0 in low bits
  input wire [2*SW*NCH-1:0] link_data_i,
  input wire link_valid_i,
  output wire link_ready_o,
  // Link mode: active channel count per converter, 1..3
  input wire [1:0] link_chan_count_i,
  // Per converter I/Q, converter 0 in low bits
  output reg [4*SW-1:0] conv_data_o,
  output reg conv_valid_o,
  input wire conv_ready_i,
  // Rate settings for the filter chains
  output reg [3:0] chan_factor_o,
  output reg [3:0] main_factor_o,
  output reg [7:0] total_factor_o,
  output reg [7:0] usable_bw_pct_o
);
  localparam DW = 2*SW*NCH;

  reg [7:0] chan_page;
  reg [7:0] interp_reg;
  reg [11:0] gain [0:NCH-1];
  reg [7:0] next_rdata;
  reg [4:0] sel_gain;
  wire [DW-1:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;
  wire [3:0] chan_f;
  wire [3:0] main_f;
  wire [DW-1:0] scaled;
  wire bypass;
  wire [7:0] total_f;
  wire use_ch1;
  wire use_ch2;
  wire [4*SW-1:0] next_conv;
  reg [1:0] cnt_sync1;
  reg [1:0] cnt_sync2;

  // Decode a main-stage code, unsupported codes fall to 1x
  function [3:0] main_decode;
    input [3:0] code;
    begin
      case (code)
        4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC: main_decode = code;
        default: main_decode = 4'h1;
      endcase
    end
  endfunction

  // Decode a channel-stage code, unsupported codes fall to bypass
  function [3:0] chan_decode;
    input [3:0] code;
    begin
      case (code)
        4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8: chan_decode = code;
        default: chan_decode = 4'h1;
      endcase
    end
  endfunction

  // Gain, rounding and saturation of one component
  function [SW-1:0] scale;
    input [SW-1:0] s;
    input [11:0] g;
    reg signed [SW+13:0] p;
    begin
      p = $signed(s) * $signed({1'b0, g});
      p = p + $signed({{(SW+3){1'b0}}, 11'h400});
      p = p >>> `CHIP_GAIN_SHIFT;
      if (p > $signed({{14{1'b0}}, `CHIP_SAMPLE_MAX})) begin
        scale = `CHIP_SAMPLE_MAX;
      end else if (p < $signed({{14{1'b1}}, `CHIP_SAMPLE_MIN})) begin
        scale = `CHIP_SAMPLE_MIN;
      end else begin
        scale = p[SW-1:0];
      end
    end
  endfunction

  // Saturating sum of three components
  function [SW-1:0] sum3;
    input [SW-1:0] a;
    input [SW-1:0] b;
    input [SW-1:0] c;
    reg signed [SW+1:0] t;
    begin
      t = $signed({{2{a[SW-1]}}, a}) + $signed({{2{b[SW-1]}}, b})
        + $signed({{2{c[SW-1]}}, c});
      if (t > $signed({2'b00, `CHIP_SAMPLE_MAX})) begin
        sum3 = `CHIP_SAMPLE_MAX;
      end else if (t < $signed({2'b11, `CHIP_SAMPLE_MIN})) begin
        sum3 = `CHIP_SAMPLE_MIN;
      end else begin
        sum3 = t[SW-1:0];
      end
    end
  endfunction

  // Is channel slot idx active for the link-mode channel count
  function lane_on;
    input [1:0] cnt;
    input [1:0] idx;
    begin
      lane_on = (cnt > idx);
    end
  endfunction

  // Usable bandwidth in percent for a total interpolation factor
  function [7:0] bw_pick;
    input [7:0] total;
    begin
      if (total > 8'h01) begin
        bw_pick = `CHIP_BW_INTERP_PCT;
      end else begin
        bw_pick = `CHIP_BW_BYPASS_PCT;
      end
    end
  endfunction

  // Lowest selected channel of a page mask, all ones when none
  function [4:0] first_sel;
    input [7:0] page;
    integer i;
    begin
      first_sel = 5'h1F;
      for (i = NCH - 1; i >= 0; i = i - 1) begin
        if (page[i]) begin
          first_sel = i[4:0];
        end
      end
    end
  endfunction

  assign chan_f = chan_decode(interp_reg[3:0]);
  assign main_f = main_decode(interp_reg[7:4]);
  assign bypass = (chan_f == 4'h1);
  // Total factor and the channel slots that the link mode fills
  assign total_f = {4'h0, chan_f} * {4'h0, main_f};
  assign use_ch1 = lane_on(cnt_sync2, 2'h1);
  assign use_ch2 = lane_on(cnt_sync2, 2'h2);

  // Sample buffer in front of the gain stage
  chip_fifo #(
    .WIDTH(DW),
    .DEPTH(`CHIP_FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_data_i(link_data_i),
    .in_valid_i(link_valid_i),
    .in_ready_o(link_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(conv_ready_i | ~conv_valid_o)
  );
  assign fifo_pop = fifo_valid & (conv_ready_i | ~conv_valid_o);

  // Gain stage per channel, first in each channel path
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_chan
      assign scaled[2*SW*gi +: SW] =
        scale(fifo_data[2*SW*gi +: SW], gain[gi]);
      assign scaled[2*SW*gi+SW +: SW] =
        scale(fifo_data[2*SW*gi+SW +: SW], gain[gi]);
    end
  endgenerate

  // Link-mode channel count is a pin, synchronised
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_sync1 <= 2'h0;
      cnt_sync2 <= 2'h0;
    end else begin
      cnt_sync1 <= link_chan_count_i;
      cnt_sync2 <= cnt_sync1;
    end
  end

  // Register writes; paged writes reach every selected channel
  integer k;
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      chan_page <= `CHIP_PAGE_RESET;
      interp_reg <= `CHIP_INTERP_RESET;
      for (k = 0; k < NCH; k = k + 1) begin
        gain[k] <= `CHIP_GAIN_RESET;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i == `CHIP_ADDR_PAGE) begin
        chan_page <= {2'h0, reg_wdata_i[5:0]};
      end
      if (reg_addr_i == `CHIP_ADDR_INTERP) begin
        interp_reg <= reg_wdata_i;
      end
      for (k = 0; k < NCH; k = k + 1) begin
        if (chan_page[k]) begin
          if (reg_addr_i == `CHIP_ADDR_GAIN_LO) begin
            gain[k] <= {gain[k][11:8], reg_wdata_i};
          end
          if (reg_addr_i == `CHIP_ADDR_GAIN_HI) begin
            gain[k] <= {reg_wdata_i[3:0], gain[k][7:0]};
          end
        end
      end
    end
  end

  // Read mux; paged reads return lowest selected channel
  always @* begin
    next_rdata = 8'h00;
    sel_gain = first_sel(chan_page);
    case (reg_addr_i)
      `CHIP_ADDR_PAGE: next_rdata = chan_page;
      `CHIP_ADDR_INTERP: next_rdata = interp_reg;
      `CHIP_ADDR_GAIN_LO: begin
        if (sel_gain != 5'h1F) begin
          next_rdata = gain[sel_gain[2:0]][7:0];
        end
      end
      `CHIP_ADDR_GAIN_HI: begin
        if (sel_gain != 5'h1F) begin
          next_rdata = {4'h0, gain[sel_gain[2:0]][11:8]};
        end
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data register
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Summing node per converter and component, bypassed at factor one
  genvar gd;
  genvar gp;
  generate
    for (gd = 0; gd < 2; gd = gd + 1) begin : g_conv
      for (gp = 0; gp < 2; gp = gp + 1) begin : g_part
        wire [SW-1:0] raw0;
        wire [SW-1:0] lane0;
        wire [SW-1:0] lane1;
        wire [SW-1:0] lane2;
        wire [SW-1:0] summed;
        // Raw channel 0 or 3 sample, used when channels are bypassed
        assign raw0 = fifo_data[(6*gd+gp)*SW +: SW];
        // Slot 0 is always in the sum
        assign lane0 = scaled[(6*gd+gp)*SW +: SW];
        // Upper slots join the sum only when the link mode uses them
        assign lane1 = use_ch1 ? scaled[(6*gd+2+gp)*SW +: SW]
                               : {SW{1'b0}};
        assign lane2 = use_ch2 ? scaled[(6*gd+4+gp)*SW +: SW]
                               : {SW{1'b0}};
        // Saturating sum, or the raw sample when bypassed
        assign summed = sum3(lane0, lane1, lane2);
        assign next_conv[(2*gd+gp)*SW +: SW] =
          bypass ? raw0 : summed;
      end
    end
  endgenerate

  // Output stage and rate settings
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_data_o <= {4*SW{1'b0}};
      conv_valid_o <= 1'b0;
      chan_factor_o <= 4'h1;
      main_factor_o <= 4'h1;
      total_factor_o <= 8'h01;
      usable_bw_pct_o <= `CHIP_BW_BYPASS_PCT;
    end else begin
      if (fifo_pop) begin
        conv_data_o <= next_conv;
        conv_valid_o <= 1'b1;
      end else if (conv_ready_i) begin
        conv_valid_o <= 1'b0;
      end
      chan_factor_o <= chan_f;
      main_factor_o <= main_f;
      total_factor_o <= total_f;
      usable_bw_pct_o <= bw_pick(total_f);
    end
  end
endmodule // chip_gain_path
`default_nettype wire

// ==== tb/cigp_props.sv ====
// Purpose: Port checks on the channel gain path
// Assumes: Rate outputs settle two edges after a write
// Notes: Bound onto every gain path instance
`default_nettype none
module cigp_props (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [63:0] conv_data_o,
  input wire logic conv_valid_o,
  input wire logic conv_ready_i,
  input wire logic [3:0] chan_factor_o,
  input wire logic [3:0] main_factor_o,
  input wire logic [7:0] total_factor_o,
  input wire logic [7:0] usable_bw_pct_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // One register write of a given byte
  sequence s_wr(a, d);
    reg_wr_i && reg_addr_i == a && reg_wdata_i == d;
  endsequence
  total_product_a: assert property (
    total_factor_o == chan_factor_o * main_factor_o)
    else $error("total factor is not the product");
  main_code_a: assert property (
    s_wr(12'h111, 8'hC3) |->
      ##2 main_factor_o == 4'hC && total_factor_o == 8'h24)
    else $error("main factor code 0xC not applied");
  chan_code_a: assert property (
    s_wr(12'h111, 8'h86) |->
      ##2 chan_factor_o == 4'h6 && total_factor_o == 8'h30)
    else $error("channel factor code 0x6 not applied");
  bad_code_a: assert property (
    s_wr(12'h111, 8'h35) |-> ##2 total_factor_o == 8'h01)
    else $error("invalid codes not treated as bypass");
  bw_select_a: assert property (
    $stable(total_factor_o) [*2] |->
      usable_bw_pct_o == (total_factor_o > 8'h01 ? 8'h50 : 8'h32))
    else $error("usable bandwidth does not match total factor");
  conv_hold_a: assert property (
    conv_valid_o && !conv_ready_i |=> conv_valid_o && $stable(conv_data_o))
    else $error("converter word dropped or changed while stalled");
  page_zero_a: assert property (
    s_wr(12'h008, 8'h00) ##[1:4] (reg_rd_i && reg_addr_i == 12'h147)
      |=> reg_rdata_o == 8'h00)
    else $error("read with empty page mask not zero");
  read_hold_a: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
endmodule // cigp_props
bind chip_gain_path cigp_props i_props (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .conv_data_o(conv_data_o),
  .conv_valid_o(conv_valid_o), .conv_ready_i(conv_ready_i),
  .chan_factor_o(chan_factor_o), .main_factor_o(main_factor_o),
  .total_factor_o(total_factor_o), .usable_bw_pct_o(usable_bw_pct_o));
`default_nettype wire

// ==== tb/cigp_link_src.sv ====
// Purpose: Link receive side that offers channel sample words
// Assumes: Ready comes from a flop, so it is read after the edge
// Notes: A released bus shows the inverse of the last word
`default_nettype none
module cigp_link_src (
  input wire logic sys_clk_i,
  input wire logic link_ready_i,
  output var logic [191:0] link_data_o,
  output var logic link_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_data_o = '0;
    link_valid_o = 1'b0;
  end
  // Hold one word until an edge takes it, eight edges at most
  task automatic send(input logic [191:0] d, output logic ok);
    ok = 1'b0;
    link_data_o = d;
    link_valid_o = 1'b1;
    for (int i = 0; i < 8 && !ok; i++) begin
      ok = link_ready_i;
      @(posedge sys_clk_i);
      #1;
    end
  endtask
  // Release the bus
  task automatic idle();
    link_valid_o = 1'b0;
    link_data_o = ~link_data_o;
  endtask
endmodule // cigp_link_src
`default_nettype wire

// ==== tb/channelizer_interp_gain_path_bench.sv ====
// Purpose: Register and stream tests of the channel gain path
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Expected sums are worked out by hand below
`default_nettype none
module channelizer_interp_gain_path_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, reset_i, reg_wr_i, reg_rd_i, link_valid_i, link_ready_o;
  logic conv_valid_o, conv_ready_i, ok;
  logic [11:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, total_factor_o, usable_bw_pct_o;
  logic [191:0] link_data_i;
  logic [1:0] link_chan_count_i;
  logic [63:0] conv_data_o;
  logic [3:0] chan_factor_o, main_factor_o;
  logic [23:0] rates, exp_r;
  int miscompares, checks, n, m;
  logic [7:0] codes [9] = '{8'hC3, 8'h86, 8'h48, 8'h62, 8'h24, 8'h11,
    8'h35, 8'h3C, 8'h83};
  logic [15:0] smp [6] = '{16'h0101, 16'h0200, 16'h0300, 16'h1000,
    16'h2000, 16'h7000};
  // All rate outputs side by side
  assign rates = {chan_factor_o, main_factor_o, total_factor_o,
    usable_bw_pct_o};
  chip_gain_path i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .link_data_i(link_data_i), .link_valid_i(link_valid_i),
    .link_ready_o(link_ready_o), .link_chan_count_i(link_chan_count_i),
    .conv_data_o(conv_data_o), .conv_valid_o(conv_valid_o),
    .conv_ready_i(conv_ready_i), .chan_factor_o(chan_factor_o),
    .main_factor_o(main_factor_o), .total_factor_o(total_factor_o),
    .usable_bw_pct_o(usable_bw_pct_o));
  cigp_link_src i_src (.sys_clk_i(sys_clk_i), .link_ready_i(link_ready_o),
    .link_data_o(link_data_i), .link_valid_o(link_valid_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // Expected factor for a nibble, bypass when unsupported
  function automatic logic [3:0] dec(input logic [3:0] c, input logic mn);
    if (c inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8} || c == (mn ? 4'hC : 4'h3))
      return c;
    return 4'h1;
  endfunction
  // Link word with equal I and Q per channel
  function automatic logic [191:0] mk();
    for (int c = 0; c < 6; c++)
      mk[32*c +: 32] = {smp[c], smp[c]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic gap(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    gap(1);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    gap(1);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    gap(1);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    gap(1);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, e);
  endtask
  // Send one word and wait for the summed converter word
  task automatic xfer(input logic [63:0] e);
    gap(3);
    i_src.send(mk(), ok);
    i_src.idle();
    for (n = 0; n < 20 && conv_valid_o !== 1'b1; n++)
      gap(1);
    if (n == 20) begin
      miscompares++;
      give_verdict();
    end
    chk(conv_data_o, e);
    gap(1);
  endtask
  initial begin
    reset_i = 1'b1;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    link_chan_count_i = 2'd3;
    conv_ready_i = 1'b1;
    gap(2);
    reset_i = 1'b0;
    rd(12'h008, 8'h3F);
    rd(12'h147, 8'h08);
    rd(12'h0FF, 8'h00);
    chk(rates, 24'h110132);
    $display("reset test done");
    foreach (codes[i]) begin
      wr(12'h111, codes[i]);
      gap(2);
      m = dec(codes[i][3:0], 0) * dec(codes[i][7:4], 1);
      exp_r = {dec(codes[i][3:0], 0), dec(codes[i][7:4], 1), m[7:0],
        m > 1 ? 8'h50 : 8'h32};
      chk(rates, exp_r);
      rd(12'h111, codes[i]);
    end
    $display("factor test done");
    wr(12'h008, 8'h09);
    wr(12'h146, 8'h00);
    wr(12'h147, 8'h04);
    wr(12'h008, 8'h02);
    rd(12'h147, 8'h08);
    wr(12'h008, 8'h08);
    rd(12'h147, 8'h04);
    wr(12'h008, 8'h00);
    wr(12'h147, 8'h0F);
    rd(12'h147, 8'h00);
    wr(12'h008, 8'h01);
    rd(12'h147, 8'h04);
    $display("paging test done");
    wr(12'h111, 8'h12);
    xfer(64'h7FFF_7FFF_0581_0581);
    link_chan_count_i = 2'd1;
    xfer(64'h0800_0800_0081_0081);
    link_chan_count_i = 2'd3;
    wr(12'h008, 8'h18);
    wr(12'h146, 8'h00);
    wr(12'h147, 8'h00);
    wr(12'h008, 8'h20);
    wr(12'h146, 8'hFF);
    wr(12'h147, 8'h0F);
    xfer(64'h7FFF_7FFF_0581_0581);
    wr(12'h111, 8'h11);
    xfer(64'h1000_1000_0101_0101);
    $display("stream test done");
    conv_ready_i = 1'b0;
    m = 0;
    ok = 1'b1;
    while (ok && m < 40) begin
      i_src.send(mk(), ok);
      m += ok;
    end
    i_src.idle();
    chk(link_ready_o, 1'b0);
    chk(m >= 16, 1'b1);
    conv_ready_i = 1'b1;
    n = 0;
    repeat (60) begin
      n += conv_valid_o;
      gap(1);
    end
    chk(n, m);
    $display("buffer test done");
    give_verdict();
  end
endmodule // channelizer_interp_gain_path_bench
`default_nettype wire
